// >>> rtl/flash_status_config_regs.sv
`timescale 1ns/100ps
`include "flash_status_regs.svh"
module flash_status_config_regs
    import flash_status_pkg::*;
#(
    parameter int NV_CYCLES = 200
) (
    // System
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Command link, on its own clock
    input wire logic link_clk_i,
    input wire logic cmd_valid_i,
    input wire flash_cmd_s cmd_i,
    // Pins and embedded engine
    input wire logic wp_n_i,
    input wire logic op_start_i,
    input wire logic op_done_i,
    // Register views
    output logic [7:0] status_one_o,
    output logic [7:0] status_two_o,
    output logic [7:0] read_config_o,
    // Decoded controls
    output logic op_allowed_o,
    output logic quad_pins_o,
    output logic hold_en_o,
    output logic nv_write_o
);
    // The timer is sixteen bits wide; a zero count would never end a write
    if (NV_CYCLES < 1 || NV_CYCLES > 65535) begin : g_bad_cycles
        $error("NV_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: latch command and flip a toggle per command
    // Reset reaches the link domain through two flops; without it the toggle
    // would start unknown and no command would ever be seen
    logic link_rst_s1_r, link_rst_s2_r;
    always_ff @(posedge link_clk_i) begin
        link_rst_s1_r <= sys_rst_i;
        link_rst_s2_r <= link_rst_s1_r;
    end
    flash_cmd_s cmd_hold_r;
    logic cmd_tog_r;
    always_ff @(posedge link_clk_i) begin
        if (link_rst_s2_r) begin
            cmd_tog_r <= 1'b0;
        end else if (cmd_valid_i) begin
            cmd_tog_r <= ~cmd_tog_r;
        end
    end
    // Command word needs no reset; it is only read after a toggle event
    always_ff @(posedge link_clk_i) begin
        if (cmd_valid_i) begin
            cmd_hold_r <= cmd_i;
        end
    end

    // Toggle crosses through two flops; held word is stable by then
    logic [2:0] tog_sync_r;
    logic wp_s1_r, wp_s2_r, st_s1_r, st_s2_r, dn_s1_r, dn_s2_r;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tog_sync_r <= 3'h0;
        end else begin
            tog_sync_r <= {tog_sync_r[1:0], cmd_tog_r};
        end
    end
    always_ff @(posedge mclk_i) begin
        wp_s1_r <= wp_n_i;
        wp_s2_r <= wp_s1_r;
        st_s1_r <= op_start_i;
        st_s2_r <= st_s1_r;
        dn_s1_r <= op_done_i;
        dn_s2_r <= dn_s1_r;
    end
    logic cmd_ev;
    assign cmd_ev = tog_sync_r[2] ^ tog_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] nv1_r, nv2_r;
    logic [7:0] vol1_r, vol2_r, s3_r;
    logic busy_r, latch_r, paused_r, resumable_r;
    wen_kind_e wen_r;
    logic [15:0] nv_cnt_r;
    logic [7:0] pend1_r, pend2_r;

    // Status write permission: lock select A with pin low blocks when quad off
    function automatic logic sr_locked(input logic [7:0] v1, input logic [7:0] v2,
                                       input logic wp_n);
        logic pin_ok;
        pin_ok = v2[`S2_QUAD] | wp_n;
        sr_locked = v2[`S2_LOCK_B] | (v1[`S1_LOCK_A] & ~pin_ok);
    endfunction : sr_locked

    logic is_wrsr, cmd_ok, locked;
    assign is_wrsr = cmd_ev && cmd_hold_r.opcode == `OP_WRSR;
    // While busy only the first status read and suspend pass
    assign cmd_ok = cmd_ev && (!busy_r || cmd_hold_r.opcode == `OP_RDSR1
                    || cmd_hold_r.opcode == `OP_SUSPEND);
    assign locked = sr_locked(vol1_r, vol2_r, wp_s2_r);

    logic [7:0] w1_nxt, w2_nxt;
    always_comb begin
        w1_nxt = (vol1_r & ~`S1_NV_MASK) | (cmd_hold_r.data1 & `S1_NV_MASK);
        w2_nxt = vol2_r & ~`S2_NV_MASK;
        if (cmd_hold_r.nbytes >= 2'd2) begin
            w2_nxt = w2_nxt | (cmd_hold_r.data2 & `S2_NV_MASK);
            // OTP lock bits only ever set
            w2_nxt = w2_nxt | (cmd_hold_r.data2 & `S2_OTP_MASK);
        end else begin
            w2_nxt = vol2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enable kind remembered until the next accepted command other than a status read
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wen_r <= WEN_NONE;
        end else if (cmd_ok) begin
            case (cmd_hold_r.opcode)
                `OP_WREN: wen_r <= WEN_NV;
                `OP_VWREN: wen_r <= WEN_VOL;
                `OP_RDSR1, `OP_RDSR2, `OP_RDSR3: wen_r <= wen_r;
                default: wen_r <= WEN_NONE;
            endcase
        end
    end

    // Write latch: set by enable or resume, cleared on completion, disable, NV status write, suspend or engine start
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            latch_r <= 1'b0;
        end else if (cmd_ok && cmd_hold_r.opcode == `OP_WREN) begin
            latch_r <= 1'b1;
        end else if (cmd_ok && (cmd_hold_r.opcode == `OP_WRDI
                     || (is_wrsr && wen_r == WEN_NV))) begin
            latch_r <= 1'b0;
        end else if (busy_r && (dn_s2_r || nv_cnt_r == 16'd1)) begin
            latch_r <= 1'b0;
        end else if (cmd_ok && cmd_hold_r.opcode == `OP_SUSPEND && busy_r) begin
            latch_r <= 1'b0;
        end else if (cmd_ok && cmd_hold_r.opcode == `OP_RESUME && paused_r) begin
            latch_r <= resumable_r;
        end else if (st_s2_r && latch_r && !busy_r) begin
            latch_r <= 1'b0;
        end
    end

    // Busy: engine start needs the latch; NV status write runs a timer
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            busy_r <= 1'b0;
            nv_cnt_r <= 16'h0;
            pend1_r <= `S1_RESET;
            pend2_r <= `S2_RESET;
        end else if (!busy_r && cmd_ok && is_wrsr && wen_r == WEN_NV && latch_r
                     && !locked) begin
            busy_r <= 1'b1;
            nv_cnt_r <= NV_CYCLES[15:0];
            pend1_r <= w1_nxt;
            pend2_r <= w2_nxt;
        end else if (!busy_r && st_s2_r && latch_r) begin
            busy_r <= 1'b1;
        end else if (nv_cnt_r > 16'd1) begin
            nv_cnt_r <= nv_cnt_r - 16'd1;
        end else if (busy_r && (nv_cnt_r == 16'd1 || dn_s2_r)) begin
            busy_r <= 1'b0;
            nv_cnt_r <= 16'h0;
        end else if (cmd_ok && cmd_hold_r.opcode == `OP_SUSPEND && busy_r
                     && nv_cnt_r == 16'h0) begin
            busy_r <= 1'b0;
        end else if (cmd_ok && cmd_hold_r.opcode == `OP_RESUME && paused_r) begin
            busy_r <= 1'b1;
        end
    end

    // Paused flag and the latch state to restore on resume
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            paused_r <= 1'b0;
            resumable_r <= 1'b0;
        end else if (cmd_ok && cmd_hold_r.opcode == `OP_SUSPEND && busy_r
                     && nv_cnt_r == 16'h0) begin
            paused_r <= 1'b1;
            resumable_r <= 1'b1;
        end else if (cmd_ok && cmd_hold_r.opcode == `OP_RESUME) begin
            paused_r <= 1'b0;
        end
    end

    // Non-volatile bits: commit at end of write time
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            nv1_r <= `S1_RESET;
            nv2_r <= `S2_RESET;
        end else if (busy_r && nv_cnt_r == 16'd1) begin
            nv1_r <= pend1_r;
            nv2_r <= pend2_r;
        end
    end

    // Volatile copies: load the reset values on reset, written by either enable path
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            vol1_r <= `S1_RESET;
            vol2_r <= `S2_RESET;
        end else if (busy_r && nv_cnt_r == 16'd1) begin
            vol1_r <= pend1_r;
            vol2_r <= pend2_r;
        end else if (cmd_ok && is_wrsr && wen_r == WEN_VOL && !locked) begin
            vol1_r <= w1_nxt;
            vol2_r <= (w2_nxt & ~`S2_OTP_MASK) | (vol2_r & `S2_OTP_MASK);
        end
    end

    // Third register: volatile, no status-protect gating
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s3_r <= `S3_RESET;
        end else if (cmd_ok && is_wrsr && wen_r == WEN_VOL && cmd_hold_r.nbytes == 2'd3) begin
            s3_r <= cmd_hold_r.data3 & `S3_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs; protection fields decoded downstream from vol copies
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            status_one_o <= `S1_RESET;
            status_two_o <= `S2_RESET;
            read_config_o <= `S3_RESET;
            op_allowed_o <= 1'b0;
            quad_pins_o <= 1'b0;
            hold_en_o <= 1'b1;
            nv_write_o <= 1'b0;
        end else begin
            status_one_o <= {vol1_r[7:2], latch_r, busy_r};
            status_two_o <= {paused_r, vol2_r[6:0]};
            read_config_o <= s3_r;
            op_allowed_o <= latch_r && !busy_r;
            quad_pins_o <= vol2_r[`S2_QUAD];
            hold_en_o <= ~vol2_r[`S2_QUAD];
            nv_write_o <= nv_cnt_r != 16'h0;
        end
    end

    // Decoded command strobes, read only by the checks below
    logic wren_ev, resume_ev, vol_wr_ev;
    assign wren_ev = cmd_ok && cmd_hold_r.opcode == `OP_WREN;
    assign resume_ev = cmd_ok && cmd_hold_r.opcode == `OP_RESUME && paused_r;
    assign vol_wr_ev = cmd_ok && is_wrsr && wen_r == WEN_VOL;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_nv_commit;
        busy_r && nv_cnt_r == 16'd1;
    endsequence
    // Steps of the command paths that the checks build on
    sequence s_vol_write;
        vol_wr_ev;
    endsequence
    sequence s_resume;
        resume_ev;
    endsequence
    sequence s_refused;
        busy_r && cmd_ev && !cmd_ok && nv_cnt_r != 16'd1;
    endsequence
    AST_WEN_SETS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cmd_ok && cmd_hold_r.opcode == `OP_WREN |=> latch_r)
        else $error("latch not set by enable");
    AST_BUSY_NEEDS_LATCH: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(busy_r) && !$past(paused_r) |-> $past(latch_r))
        else $error("busy without latch");
    AST_S3_RSVD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !s3_r[7]) else $error("reserved bit set");
    AST_LOCK0: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        nv2_r[2]) else $error("lock bit 0 clear");
    AST_COMMIT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_nv_commit |=> !busy_r && nv1_r == $past(pend1_r) && !latch_r)
        else $error("nv commit wrong");
    AST_QUAD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        quad_pins_o != hold_en_o) else $error("quad and hold agree");
    AST_BUSY_OUT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ##1 status_one_o[0] == $past(busy_r)) else $error("busy view wrong");
    AST_PAUSE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(paused_r) |-> !busy_r) else $error("paused while busy");

    // The latch only rises on an enable or when a suspended operation resumes
    AST_LATCH_SRC: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(latch_r) |-> $past(wren_ev) || $past(resume_ev))
        else $error("latch set by other command");

    // A status write never raises the write latch
    AST_WRSR_RO: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cmd_ok && is_wrsr |=> !$rose(latch_r))
        else $error("status write raised latch");

    // Commands refused while busy leave the enable kind, first status copy and third register alone
    AST_REFUSED: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_refused |=> $stable(wen_r) && $stable(vol1_r) && $stable(s3_r))
        else $error("command taken while busy");

    // Volatile writes start no timer and leave the stored bits alone
    AST_VOL_NO_NV: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_vol_write |=> nv_cnt_r == 16'h0 && $stable(nv1_r) && $stable(nv2_r))
        else $error("volatile write touched stored bits");

    // A locked volatile write leaves both status copies unchanged
    AST_VOL_LOCKED: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_vol_write ##0 locked |=> $stable(vol1_r) && $stable(vol2_r))
        else $error("locked volatile write applied");

    // An open volatile write lands in the working copy
    AST_VOL_OPEN: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_vol_write ##0 !locked |=> vol1_r == $past(w1_nxt))
        else $error("volatile write lost");

    // Third register takes its byte whatever the lock state
    AST_S3_FREE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_vol_write ##0 cmd_hold_r.nbytes == 2'd3
        |=> s3_r[6:0] == $past(cmd_hold_r.data3[6:0]))
        else $error("third register write lost");

    // Lock bits are one-time: once set they never clear
    AST_OTP_STICKY: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (($past(vol2_r) & ~vol2_r) & `S2_OTP_MASK) == 8'h00)
        else $error("lock bit cleared");

    // Resume ends the pause and restarts the operation
    AST_RESUME: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_resume |=> !paused_r && busy_r)
        else $error("resume not applied");

    // A pause only follows a running operation
    AST_SUS_BUSY: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(paused_r) |-> $past(busy_r))
        else $error("pause without operation");

    // Allowed view follows latch and busy one cycle later
    AST_ALLOWED: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ##1 op_allowed_o == ($past(latch_r) && !$past(busy_r)))
        else $error("allowed view wrong");

    // Second register view shows the working copy
    AST_S2_VIEW: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ##1 status_two_o[6:0] == $past(vol2_r[6:0]))
        else $error("second register view wrong");

    // Each command is seen once, so no command is applied twice
    AST_CMD_ONCE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cmd_ev |=> !cmd_ev)
        else $error("command event too long");
endmodule : flash_status_config_regs

// >>> rtl/flash_status_pkg.sv
package flash_status_pkg;
    typedef enum logic [1:0] {WEN_NONE, WEN_NV, WEN_VOL} wen_kind_e;
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] data1;
        logic [7:0] data2;
        logic [7:0] data3;
        logic [1:0] nbytes;
    } flash_cmd_s;
endpackage : flash_status_pkg

// >>> rtl/flash_status_regs.svh
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH
// Command opcodes
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_VWREN 8'h50
`define OP_WRSR 8'h01
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h33
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
// Field positions
`define S1_BUSY 0
`define S1_WLATCH 1
`define S1_LOCK_A 7
`define S2_LOCK_B 0
`define S2_QUAD 1
`define S2_INVERT 6
`define S2_PAUSED 7
// Writable masks and reset values
`define S1_NV_MASK 8'hfc
`define S2_NV_MASK 8'h43
`define S2_OTP_MASK 8'h3c
`define S3_MASK 8'h7f
`define S1_RESET 8'h00
`define S2_RESET 8'h04
`define S3_RESET 8'h70
// Embedded write time of a non-volatile status write
`define NV_WRITE_CYCLES 16'd200
`endif

// >>> verif/host_link_model.sv
`timescale 1ns/100ps
`include "flash_status_regs.svh"
module host_link_model
    import flash_status_pkg::*;
(
    // Link side
    input wire logic link_clk_i,
    output logic cmd_valid_o,
    output flash_cmd_s cmd_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One command, valid for one link edge; idle data is inverted so it is never stale
    task automatic send(input logic [7:0] op, input logic [23:0] d, input logic [1:0] n);
        @(posedge link_clk_i);
        #1;
        cmd_o = '{opcode: op, data1: d[23:16], data2: d[15:8], data3: d[7:0], nbytes: n};
        cmd_valid_o = 1'b1;
        @(posedge link_clk_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_o = ~cmd_o;
        // Spacing well above four system clocks
        repeat (3) @(posedge link_clk_i);
    endtask : send
    // Enable always directly before the status write
    task automatic wr(input logic vol, input logic [23:0] d, input logic [1:0] n);
        send(vol ? `OP_VWREN : `OP_WREN, 24'h0, 2'd0);
        send(`OP_WRSR, d, n);
    endtask : wr
endmodule : host_link_model

// >>> verif/testbench.sv
`timescale 1ns/100ps
`include "flash_status_regs.svh"
module testbench
    import flash_status_pkg::*;
;
    logic mclk_i, sys_rst_i, link_clk_i, wp_n_i, cmd_valid;
    flash_cmd_s cmd;
    logic [7:0] s1, s2, s3, d1, d2, d3;
    logic op_ok, quad, hold, nvw, op_start, op_done;
    int error_cnt = 0;
    int checked = 0;
    // Long enough to watch commands arrive while the engine is busy
    localparam int NVC = 40;
    ////////////////////////////////////////////////////////////////////////////////
    // Clocks, unrelated in phase
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #7;
        forever #32 link_clk_i = ~link_clk_i;
    end
    host_link_model host (.link_clk_i(link_clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd));
    flash_status_config_regs #(.NV_CYCLES(NVC)) DUT (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
        .cmd_valid_i(cmd_valid), .cmd_i(cmd), .wp_n_i(wp_n_i),
        .op_start_i(op_start), .op_done_i(op_done),
        .status_one_o(s1), .status_two_o(s2), .read_config_o(s3),
        .op_allowed_o(op_ok), .quad_pins_o(quad), .hold_en_o(hold), .nv_write_o(nvw)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Quad bit and complement are writable, paused and OTP bits are not
    function automatic logic [7:0] exp_two(input logic [7:0] d);
        return (d & 8'h42) | `S2_RESET;
    endfunction : exp_two
    task automatic settle();
        repeat (8) @(posedge mclk_i);
        #1;
    endtask : settle
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // Watchdog
    initial begin
        #400000;
        error_cnt++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst_i = 1'b1;
        wp_n_i = 1'b1;
        op_start = 1'b0;
        op_done = 1'b0;
        void'($urandom(32'h62aa));
        repeat (6) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        settle();
        chk("one", `S1_RESET, s1);
        chk("two", `S2_RESET, s2);
        chk("cfg", `S3_RESET, s3);
        chk("pins", 8'h01, {quad, hold});
        $display("reset test done");
        // Status write with no enable in front of it
        host.send(`OP_WRSR, 24'h1c0000, 2'd1);
        settle();
        chk("one", 8'h00, s1);
        host.send(`OP_WREN, 24'h0, 2'd0);
        settle();
        chk("latch", 8'h05, {s1[1:0], op_ok});
        // Non-volatile write, with a volatile write refused while busy
        d1 = 8'($urandom()) & 8'h7c;
        host.send(`OP_WRSR, {d1, 16'h0}, 2'd1);
        settle();
        chk("busy", 8'h03, {s1[0], nvw});
        chk("allow", 8'h00, {7'h0, op_ok});
        host.wr(1'b1, 24'h000055, 2'd3);
        for (int i = 0; i < 200 && s1[0] !== 1'b0; i++) @(posedge mclk_i);
        settle();
        chk("one", d1, s1);
        chk("cfg", `S3_RESET, s3);
        $display("nv test done");
        // Volatile writes of all three registers, reserved bits set on the first
        for (int i = 0; i < 5; i++) begin
            d1 = 8'($urandom());
            d2 = 8'($urandom()) & 8'hc2;
            d3 = (i == 0) ? 8'hff : 8'($urandom());
            host.wr(1'b1, {d1, d2, d3}, 2'd3);
            settle();
            chk("one", d1 & `S1_NV_MASK, s1);
            chk("two", exp_two(d2), s2);
            chk("cfg", d3 & `S3_MASK, s3);
            chk("pins", {6'h0, d2[1], ~d2[1]}, {6'h0, quad, hold});
            chk("nvw", 8'h00, {7'h0, nvw});
        end
        $display("volatile test done");
        // Lock select with the pin low: only the third register is writable
        host.wr(1'b1, 24'h800070, 2'd3);
        wp_n_i = 1'b0;
        host.wr(1'b1, 24'h1c4015, 2'd3);
        settle();
        chk("one", 8'h80, s1);
        chk("two", `S2_RESET, s2);
        chk("cfg", 8'h15, s3);
        wp_n_i = 1'b1;
        host.wr(1'b1, 24'h1c0070, 2'd3);
        settle();
        chk("one", 8'h1c, s1);
        $display("lock test done");
        // Engine start refused without the latch, then start, suspend, resume, done
        op_start = 1'b1;
        settle();
        op_start = 1'b0;
        chk("eng", 8'h00, {6'h0, s1[1:0]});
        host.send(`OP_WREN, 24'h0, 2'd0);
        op_start = 1'b1;
        settle();
        op_start = 1'b0;
        chk("eng", 8'h01, {6'h0, s1[1:0]});
        host.send(`OP_SUSPEND, 24'h0, 2'd0);
        settle();
        chk("susp", 8'h04, {5'h0, s2[7], s1[1:0]});
        host.send(`OP_RESUME, 24'h0, 2'd0);
        settle();
        chk("resume", 8'h03, {5'h0, s2[7], s1[1:0]});
        op_done = 1'b1;
        settle();
        op_done = 1'b0;
        chk("done", 8'h00, {5'h0, s2[7], s1[1:0]});
        $display("engine test done");
        test_done();
    end
endmodule : testbench
